//--- logic/eiec_top.v
// Behaviour
// - Seven maskable external inputs plus one NMI
// - Sources 5-7 come from internal controllers
// - Group A holds four 2-bit edge fields
// - Group A read/write, clears to 00H
// - Group B selects edges for sources 4-7
// - Group B clears to 00H on reset
// - Inputs 8 and 9 share one edge field
// - Control bits 4-5 select NMI edge
// - Control bit 7 enables priority control
// - Control bit 6 reads NMI pin level
// - Control bits 0-3,6 read-only; read 0,0,1,1
// - Control resets to 0CH or 4CH by pin
// - Pair select bits enable inputs 8 and 9
// - Pair select bits 2-7 read zero
// - Pair select clears to 00H on reset
// - Selected edge sets the source request flag
// - Maskable request forwarded only when enable set
// - Two priority flags per maskable source
// - Inputs 8 and 9 share one request flag
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "eiec_regs.vh"

module eiec_top (
   // Clock and reset
   input  wire       I_CORE_CLK,
   input  wire       I_SYS_RST,
   // Register port
   input  wire [7:0] I_ADDR,
   input  wire [7:0] I_WDATA,
   input  wire       I_WR,
   input  wire       I_RD,
   output wire [7:0] O_RDATA,
   // External pins
   input  wire [3:0] I_EXT_INPUT,
   input  wire       I_BUS_POWER_PIN,
   input  wire       I_EXT_INPUT_8,
   input  wire       I_EXT_INPUT_9,
   input  wire       I_NMI_PIN,
   // Internal controller request lines
   input  wire       I_USB_REQUEST_LINE,
   input  wire       I_DMA_REQUEST_LINE,
   input  wire       I_MEDIA_REQUEST_LINE,
   // Requests towards the processor
   output wire [8:0] O_INT_REQ,
   output wire       O_NMI_REQ,
   output wire [8:0] O_INT_PRIO0,
   output wire [8:0] O_INT_PRIO1,
   output wire       O_PRIO_CTRL_EN
);

   // Selected edge seen for one source
   // Code 00 and any unknown code give no hit
   function edge_hit;
      input [1:0] mode;
      input       rise;
      input       fall;
      begin
         case (mode)
            `EIEC_EDGE_FALL: edge_hit = fall;
            `EIEC_EDGE_RISE: edge_hit = rise;
            `EIEC_EDGE_BOTH: edge_hit = rise | fall;
            default:         edge_hit = 1'b0;
         endcase
      end
   endfunction

   // Reset images held as vectors, so that their fields can be sliced
   localparam [7:0] NMI_PRI_RST  = `EIEC_RST_NMI_PRI;
   localparam [7:0] PAIR_SEL_RST = `EIEC_RST_PAIR_SEL;

   // Software registers
   reg  [7:0]  edge_a_q;
   reg  [7:0]  edge_b_q;
   reg  [1:0]  pair_edge_q;
   reg  [1:0]  nmi_edge_q;
   reg         prio_en_q;
   reg  [1:0]  pair_sel_q;
   reg  [7:0]  en_a_q;
   reg         en_b_q;
   reg  [7:0]  pri0_a_q;
   reg  [7:0]  pri1_a_q;
   reg  [1:0]  pri_b_q;

   // Request flags and their next values
   reg  [8:0]  req_q;
   reg  [8:0]  req_d;
   reg         nmi_q;
   reg         nmi_d;

   // Output flops
   reg  [7:0]  rdata_q;
   reg  [7:0]  rdata_d;
   reg  [8:0]  int_req_q;
   reg         nmi_req_q;
   reg  [8:0]  prio0_q;
   reg  [8:0]  prio1_q;
   reg         prio_en_out_q;

   // Synchronised pins and edges
   wire [7:0]  pin_sync;
   wire [10:0] level;
   wire [10:0] rise;
   wire [10:0] fall;
   wire [7:0]  src_hit;
   wire        pair_hit;
   wire        nmi_hit;
   wire [15:0] modes;
   wire        nmi_level;
   wire [7:0]  nmi_pri_rd;

   // Write decodes
   wire        wr_edge_a    = I_WR & (I_ADDR == `EIEC_ADDR_EDGE_A);
   wire        wr_edge_b    = I_WR & (I_ADDR == `EIEC_ADDR_EDGE_B);
   wire        wr_nmi_pri   = I_WR & (I_ADDR == `EIEC_ADDR_NMI_PRI);
   wire        wr_pair_sel  = I_WR & (I_ADDR == `EIEC_ADDR_PAIR_SEL);
   wire        wr_pair_edge = I_WR & (I_ADDR == `EIEC_ADDR_PAIR_EDGE);
   wire        wr_req_a     = I_WR & (I_ADDR == `EIEC_ADDR_REQ_A);
   wire        wr_req_b     = I_WR & (I_ADDR == `EIEC_ADDR_REQ_B);
   wire        wr_en_a      = I_WR & (I_ADDR == `EIEC_ADDR_EN_A);
   wire        wr_en_b      = I_WR & (I_ADDR == `EIEC_ADDR_EN_B);
   wire        wr_pri0_a    = I_WR & (I_ADDR == `EIEC_ADDR_PRI0_A);
   wire        wr_pri1_a    = I_WR & (I_ADDR == `EIEC_ADDR_PRI1_A);
   wire        wr_pri_b     = I_WR & (I_ADDR == `EIEC_ADDR_PRI_B);

   // Pins cross into the core clock through two flops
   // The first stage may go metastable and is read by nothing else
   eiec_sync #(
      .W (8)
   ) u_sync (
      .i_clk   (I_CORE_CLK),
      .i_async ({I_NMI_PIN, I_EXT_INPUT_9, I_EXT_INPUT_8,
                 I_BUS_POWER_PIN, I_EXT_INPUT}),
      .o_sync  (pin_sync)
   );

   // Internal lines are already on the core clock and skip the chain
   // Delaying them as well would only slow their requests down
   assign level = {pin_sync[7:5], I_MEDIA_REQUEST_LINE, I_DMA_REQUEST_LINE,
                   I_USB_REQUEST_LINE, pin_sync[4:0]};

   // Edge detection on every source
   // Internal lines hit in the cycle they move, pins two cycles after
   eiec_edge #(
      .W (11)
   ) u_edge (
      .i_clk   (I_CORE_CLK),
      .i_level (level),
      .o_rise  (rise),
      .o_fall  (fall)
   );

   // Sources 0-3 from group A, 4-7 from group B
   // Field n of the combined vector belongs to source n
   assign modes = {edge_b_q, edge_a_q};

   // Selected-edge qualification for sources 0 to 7
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_src
         assign src_hit[gi] = edge_hit(modes[2*gi+1:2*gi], rise[gi], fall[gi]);
      end
   endgenerate

   // Inputs 8 and 9 share one field and one flag, each gated by its enable
   // A disabled input of the pair is ignored even while its partner is on
   assign pair_hit =
      (edge_hit(pair_edge_q, rise[8], fall[8]) & pair_sel_q[`EIEC_IN8_EN_BIT]) |
      (edge_hit(pair_edge_q, rise[9], fall[9]) & pair_sel_q[`EIEC_IN9_EN_BIT]);

   // Non-maskable input edge
   assign nmi_hit = edge_hit(nmi_edge_q, rise[10], fall[10]);

   // Synchronised NMI pin level for monitoring
   assign nmi_level = pin_sync[7];

   // Control register as read: fixed low nibble and live pin level
   // The pin bit follows the pin two cycles late, also during reset
   assign nmi_pri_rd = {prio_en_q, nmi_level, nmi_edge_q, 4'h0} |
                       `EIEC_NMI_FIXED_BITS;

   // Request flags: software writes, hardware sets; set wins over clear
   // A hit in the same cycle as a software clear keeps its flag set,
   // so a request arriving during a clear is never lost
   always @* begin
      req_d = req_q;
      nmi_d = nmi_q;
      if (wr_req_a) begin
         req_d[7:0] = I_WDATA;
      end
      if (wr_req_b) begin
         req_d[8] = I_WDATA[`EIEC_PAIR_BIT];
         nmi_d    = I_WDATA[`EIEC_NMI_FLAG_BIT];
      end
      req_d = req_d | {pair_hit, src_hit};
      nmi_d = nmi_d | nmi_hit;
   end

   // Read data multiplexer; unmapped addresses read zero
   always @* begin
      rdata_d = 8'h00;
      case (I_ADDR)
         `EIEC_ADDR_EDGE_A:    rdata_d = edge_a_q;
         `EIEC_ADDR_EDGE_B:    rdata_d = edge_b_q;
         `EIEC_ADDR_NMI_PRI:   rdata_d = nmi_pri_rd;
         `EIEC_ADDR_PAIR_SEL:  rdata_d = {6'h00, pair_sel_q};
         `EIEC_ADDR_PAIR_EDGE: rdata_d = {6'h00, pair_edge_q};
         `EIEC_ADDR_REQ_A:     rdata_d = req_q[7:0];
         `EIEC_ADDR_REQ_B:     rdata_d = {6'h00, nmi_q, req_q[8]};
         `EIEC_ADDR_EN_A:      rdata_d = en_a_q;
         `EIEC_ADDR_EN_B:      rdata_d = {7'h00, en_b_q};
         `EIEC_ADDR_PRI0_A:    rdata_d = pri0_a_q;
         `EIEC_ADDR_PRI1_A:    rdata_d = pri1_a_q;
         `EIEC_ADDR_PRI_B:     rdata_d = {6'h00, pri_b_q};
         default:              rdata_d = 8'h00;
      endcase
   end

   // Edge select registers, cleared by every reset source
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         edge_a_q    <= `EIEC_RST_EDGE_A;
         edge_b_q    <= `EIEC_RST_EDGE_B;
         pair_edge_q <= 2'b00;
      end else begin
         if (wr_edge_a) begin
            edge_a_q <= I_WDATA;
         end
         if (wr_edge_b) begin
            edge_b_q <= I_WDATA;
         end
         if (wr_pair_edge) begin
            pair_edge_q <= I_WDATA[1:0];
         end
      end
   end

   // NMI edge and priority enable; other bits of that register are fixed
   // The pin-level bit has no storage: reads take it live
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         nmi_edge_q <= NMI_PRI_RST[`EIEC_NMI_EDGE_LSB+1:`EIEC_NMI_EDGE_LSB];
         prio_en_q  <= NMI_PRI_RST[`EIEC_PRI_EN_BIT];
      end else if (wr_nmi_pri) begin
         nmi_edge_q <= I_WDATA[`EIEC_NMI_EDGE_LSB+1:`EIEC_NMI_EDGE_LSB];
         prio_en_q  <= I_WDATA[`EIEC_PRI_EN_BIT];
      end
   end

   // Input pair select; upper bits are not stored
   // Bits 2 to 7 therefore always read zero
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         pair_sel_q <= PAIR_SEL_RST[1:0];
      end else if (wr_pair_sel) begin
         pair_sel_q <= I_WDATA[1:0];
      end
   end

   // Enable and priority flags
   // Priority flags are only passed out; ordering is done further on
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         en_a_q   <= `EIEC_RST_FLAGS;
         en_b_q   <= 1'b0;
         pri0_a_q <= `EIEC_RST_FLAGS;
         pri1_a_q <= `EIEC_RST_FLAGS;
         pri_b_q  <= 2'b00;
      end else begin
         if (wr_en_a) begin
            en_a_q <= I_WDATA;
         end
         if (wr_en_b) begin
            en_b_q <= I_WDATA[`EIEC_PAIR_BIT];
         end
         if (wr_pri0_a) begin
            pri0_a_q <= I_WDATA;
         end
         if (wr_pri1_a) begin
            pri1_a_q <= I_WDATA;
         end
         if (wr_pri_b) begin
            pri_b_q <= I_WDATA[1:0];
         end
      end
   end

   // Request flag storage
   // Flags clear on every reset source, like the control registers
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         req_q <= 9'h000;
         nmi_q <= 1'b0;
      end else begin
         req_q <= req_d;
         nmi_q <= nmi_d;
      end
   end

   // Read data stands in the cycle after the read strobe only
   // Idling at zero keeps stale data off the shared read bus
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         rdata_q <= 8'h00;
      end else if (I_RD) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // Registered request and priority outputs
   // Requests reach the core one cycle after their flag is set
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         int_req_q     <= 9'h000;
         nmi_req_q     <= 1'b0;
         prio0_q       <= 9'h000;
         prio1_q       <= 9'h000;
         prio_en_out_q <= 1'b0;
      end else begin
         int_req_q     <= req_q & {en_b_q, en_a_q};
         nmi_req_q     <= nmi_q;
         prio0_q       <= {pri_b_q[0], pri0_a_q};
         prio1_q       <= {pri_b_q[1], pri1_a_q};
         prio_en_out_q <= prio_en_q;
      end
   end

   assign O_RDATA        = rdata_q;
   assign O_INT_REQ      = int_req_q;
   assign O_NMI_REQ      = nmi_req_q;
   assign O_INT_PRIO0    = prio0_q;
   assign O_INT_PRIO1    = prio1_q;
   assign O_PRIO_CTRL_EN = prio_en_out_q;

endmodule

`default_nettype wire

//--- include/eiec_regs.vh
`ifndef EIEC_REGS_VH
`define EIEC_REGS_VH

// Register byte offsets
`define EIEC_ADDR_EDGE_A     8'h58
`define EIEC_ADDR_EDGE_B     8'h59
`define EIEC_ADDR_NMI_PRI    8'h5a
`define EIEC_ADDR_PAIR_SEL   8'h5b
`define EIEC_ADDR_PAIR_EDGE  8'h5c
`define EIEC_ADDR_REQ_A      8'h60
`define EIEC_ADDR_REQ_B      8'h61
`define EIEC_ADDR_EN_A       8'h62
`define EIEC_ADDR_EN_B       8'h63
`define EIEC_ADDR_PRI0_A     8'h64
`define EIEC_ADDR_PRI1_A     8'h65
`define EIEC_ADDR_PRI_B      8'h66

// Reset values
`define EIEC_RST_EDGE_A      8'h00
`define EIEC_RST_EDGE_B      8'h00
`define EIEC_RST_NMI_PRI     8'h0c
`define EIEC_RST_PAIR_SEL    8'h00
`define EIEC_RST_FLAGS       8'h00

// Edge field encodings
`define EIEC_EDGE_OFF        2'b00
`define EIEC_EDGE_FALL       2'b01
`define EIEC_EDGE_RISE       2'b10
`define EIEC_EDGE_BOTH       2'b11

// Field positions in the NMI and priority control register
`define EIEC_NMI_EDGE_LSB    4
`define EIEC_NMI_LEVEL_BIT   6
`define EIEC_PRI_EN_BIT      7
`define EIEC_NMI_FIXED_BITS  8'h0c

// Field positions in the input pair select register
`define EIEC_IN8_EN_BIT      0
`define EIEC_IN9_EN_BIT      1

// Flag positions in the second request and enable registers
`define EIEC_PAIR_BIT        0
`define EIEC_NMI_FLAG_BIT    1

`endif

//--- logic/eiec_sync.v
`timescale 1ns/100ps
`default_nettype none

module eiec_sync #(
   parameter W = 8
) (
   // Clock
   input  wire         i_clk,
   // Asynchronous inputs and their synchronised copies
   input  wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // Two flip-flop chain; only the second stage is read outside
   always @(posedge i_clk) begin
      meta_q <= i_async;
      sync_q <= meta_q;
   end

   assign o_sync = sync_q;

endmodule

`default_nettype wire

//--- logic/eiec_edge.v
`timescale 1ns/100ps
`default_nettype none

module eiec_edge #(
   parameter W = 11
) (
   // Clock
   input  wire         i_clk,
   // Levels on the core clock and their edges
   input  wire [W-1:0] i_level,
   output wire [W-1:0] o_rise,
   output wire [W-1:0] o_fall
);

   reg [W-1:0] prev_q;

   // Previous level; no reset, so no false edge appears at release
   always @(posedge i_clk) begin
      prev_q <= i_level;
   end

   // Edges compare the present level with the one before
   assign o_rise = i_level & ~prev_q;
   assign o_fall = ~i_level & prev_q;

endmodule

`default_nettype wire

//--- testbench/eiec_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "eiec_regs.vh"
module eiec_monitor (
   // Clock and reset
   input wire logic       I_CORE_CLK,
   input wire logic       I_SYS_RST,
   // Register port
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic       I_WR,
   input wire logic       I_RD,
   input wire logic [7:0] O_RDATA,
   // Pin and requests
   input wire logic       I_NMI_PIN,
   input wire logic [8:0] O_INT_REQ,
   input wire logic       O_NMI_REQ,
   input wire logic       O_PRIO_CTRL_EN
);
   logic [7:0] en_q;
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);
   // Shadow of the enable register for sources 0 to 7
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST)
         en_q <= 8'h00;
      else if (I_WR && I_ADDR == `EIEC_ADDR_EN_A)
         en_q <= I_WDATA;
   end
   // Write then read of one register, back to back
   sequence s_wa;
      I_WR && I_ADDR == `EIEC_ADDR_EDGE_A ##1 I_RD && I_ADDR == `EIEC_ADDR_EDGE_A;
   endsequence
   sequence s_wb;
      I_WR && I_ADDR == `EIEC_ADDR_EDGE_B ##1 I_RD && I_ADDR == `EIEC_ADDR_EDGE_B;
   endsequence
   // Request seen, and no flag write in the cycle before it
   sequence s_held;
      O_NMI_REQ && !$past(I_WR && I_ADDR == `EIEC_ADDR_REQ_B);
   endsequence
   sequence s_calm;
      $stable(I_NMI_PIN)[*4] ##0 I_RD && I_ADDR == `EIEC_ADDR_NMI_PRI;
   endsequence
   AST_EDGE_A: assert property (s_wa |=> O_RDATA == $past(I_WDATA, 2))
      else $error("group A readback differs");
   AST_EDGE_B: assert property (s_wb |=> O_RDATA == $past(I_WDATA, 2))
      else $error("group B readback differs");
   AST_NMI_FIXED: assert property (I_RD && I_ADDR == `EIEC_ADDR_NMI_PRI |=> O_RDATA[3:0] == 4'hc)
      else $error("control low nibble not fixed");
   AST_PAIR_HI: assert property (I_RD && I_ADDR == `EIEC_ADDR_PAIR_SEL |=> O_RDATA[7:2] == 6'h00)
      else $error("pair select upper bits set");
   AST_PRIO_EN: assert property (I_WR && I_ADDR == `EIEC_ADDR_NMI_PRI |-> ##2 O_PRIO_CTRL_EN == $past(I_WDATA[7], 2))
      else $error("priority enable not following");
   AST_NMI_LEVEL: assert property (s_calm |=> O_RDATA[6] == $past(I_NMI_PIN))
      else $error("pin level bit wrong");
   AST_REQ_GATE: assert property ((O_INT_REQ[7:0] & ~$past(en_q)) == 8'h00)
      else $error("request passed while disabled");
   AST_NMI_STICKY: assert property (s_held |=> O_NMI_REQ)
      else $error("nmi request dropped");
   AST_RST_OUT: assert property (disable iff (1'b0) I_SYS_RST |=> O_INT_REQ == 9'h000 && !O_NMI_REQ && !O_PRIO_CTRL_EN && O_RDATA == 8'h00)
      else $error("outputs not cleared by reset");
endmodule
bind eiec_top eiec_monitor eiec_monitor_inst (.I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST),
   .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .I_NMI_PIN(I_NMI_PIN), .O_INT_REQ(O_INT_REQ), .O_NMI_REQ(O_NMI_REQ),
   .O_PRIO_CTRL_EN(O_PRIO_CTRL_EN));
`default_nettype wire

//--- testbench/eiec_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
module eiec_pins_model (
   // Clock
   input  wire logic        i_clk,
   // Levels: 3:0 inputs, 4 bus power, 5/6 pair, 7 nmi, 8 usb, 9 dma, 10 media
   output var  logic [10:0] o_lv
);
   // Pins start low, already set up as alternate-function inputs
   initial o_lv = 11'h000;
   // Move one line, promptly or after some edges
   task automatic set(input int i, input logic v, input int slow);
      repeat (slow) @(posedge i_clk);
      o_lv[i] <= v;
   endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "eiec_regs.vh"
module testbench;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr_s = 1'b0;
   logic       rd_s = 1'b0;
   logic [10:0] lv;
   wire [7:0]  rdata;
   wire [8:0]  req;
   wire [8:0]  pr0;
   wire [8:0]  pr1;
   wire        nmi_req;
   wire        pen;
   int         n_fail = 0;
   int         samples_checked = 0;
   int         cyc = 0;
   int         m;
   eiec_pins_model pins (.i_clk(clk), .o_lv(lv));
   eiec_top eiec_top_inst (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_EXT_INPUT(lv[3:0]),
      .I_BUS_POWER_PIN(lv[4]), .I_EXT_INPUT_8(lv[5]), .I_EXT_INPUT_9(lv[6]),
      .I_NMI_PIN(lv[7]), .I_USB_REQUEST_LINE(lv[8]), .I_DMA_REQUEST_LINE(lv[9]),
      .I_MEDIA_REQUEST_LINE(lv[10]), .O_INT_REQ(req), .O_NMI_REQ(nmi_req),
      .O_INT_PRIO0(pr0), .O_INT_PRIO1(pr1), .O_PRIO_CTRL_EN(pen));
   // Core clock, 100 MHz
   always #5 clk = ~clk;
   task report_and_stop;
      if (n_fail == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         report_and_stop;
      end
   end
   task chk(input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk({1'b0, rdata}, {1'b0, e});
      @(posedge clk);
   endtask
   // Write, then read back in the very next cycle
   task wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk({1'b0, rdata}, {1'b0, e});
      @(posedge clk);
   endtask
   task pin(input int i, input logic v);
      pins.set(i, v, 0);
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`EIEC_ADDR_EDGE_A, 8'h00);
      rd(`EIEC_ADDR_EDGE_B, 8'h00);
      rd(`EIEC_ADDR_NMI_PRI, 8'h0c);
      rd(`EIEC_ADDR_PAIR_SEL, 8'h00);
      wr_rd(`EIEC_ADDR_EDGE_A, 8'h5a, 8'h5a);
      wr_rd(`EIEC_ADDR_EDGE_B, 8'ha5, 8'ha5);
      wr_rd(`EIEC_ADDR_PAIR_SEL, 8'h03, 8'h03);
      wr_rd(8'h70, 8'hff, 8'h00);
      wr_rd(`EIEC_ADDR_NMI_PRI, 8'hff, 8'hbc);
      // Every edge code on input 0, with its request enabled
      wr(`EIEC_ADDR_EN_A, 8'h01);
      for (m = 0; m < 4; m++) begin
         wr(`EIEC_ADDR_EDGE_A, m[7:0]);
         wr(`EIEC_ADDR_REQ_A, 8'h00);
         pin(0, 1'b1);
         rd(`EIEC_ADDR_REQ_A, {7'h00, m[1]});
         chk(req, {8'h00, m[1]});
         wr(`EIEC_ADDR_REQ_A, 8'h00);
         pin(0, 1'b0);
         rd(`EIEC_ADDR_REQ_A, {7'h00, m[0]});
      end
      // Rising edges on all four inputs, some arriving late
      wr(`EIEC_ADDR_EDGE_A, 8'ha8);
      wr(`EIEC_ADDR_REQ_A, 8'h00);
      for (m = 0; m < 4; m++)
         pins.set(m, 1'b1, m);
      repeat (8) @(posedge clk);
      rd(`EIEC_ADDR_REQ_A, 8'h0e);
      // Internal lines with their proper edges, bus power pin switched off
      wr(`EIEC_ADDR_EDGE_B, 8'h94);
      wr(`EIEC_ADDR_REQ_A, 8'h00);
      for (m = 4; m < 11; m++)
         if (m < 5 || m > 7)
            pin(m, 1'b1);
      pin(8, 1'b0);
      pin(9, 1'b0);
      pin(4, 1'b0);
      rd(`EIEC_ADDR_REQ_A, 8'he0);
      // Pair inputs: only input 8 enabled
      wr(`EIEC_ADDR_PAIR_EDGE, 8'h02);
      wr(`EIEC_ADDR_PAIR_SEL, 8'h01);
      pin(6, 1'b1);
      rd(`EIEC_ADDR_REQ_B, 8'h00);
      pin(5, 1'b1);
      rd(`EIEC_ADDR_REQ_B, 8'h01);
      // Pair request forwarded once its enable is set
      wr(`EIEC_ADDR_EN_B, 8'h01);
      @(negedge clk);
      chk(req, 9'h100);
      @(posedge clk);
      // Priority enable off, then on, then a rising edge on the nmi pin
      wr(`EIEC_ADDR_NMI_PRI, 8'h20);
      @(negedge clk);
      chk(pen, 9'h000);
      @(posedge clk);
      wr(`EIEC_ADDR_NMI_PRI, 8'ha0);
      @(negedge clk);
      chk(pen, 9'h001);
      @(posedge clk);
      pin(7, 1'b1);
      chk(nmi_req, 9'h001);
      rd(`EIEC_ADDR_REQ_B, 8'h03);
      rd(`EIEC_ADDR_NMI_PRI, 8'hec);
      // Software clear of both flags in the second flag register
      wr(`EIEC_ADDR_REQ_B, 8'h00);
      rd(`EIEC_ADDR_REQ_B, 8'h00);
      chk(nmi_req, 9'h000);
      wr(`EIEC_ADDR_PRI0_A, 8'h0f);
      wr(`EIEC_ADDR_PRI1_A, 8'hf0);
      wr(`EIEC_ADDR_PRI_B, 8'h03);
      @(negedge clk);
      chk(pr0, 9'h10f);
      chk(pr1, 9'h1f0);
      @(posedge clk);
      // Second reset with the nmi pin high
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`EIEC_ADDR_NMI_PRI, 8'h4c);
      rd(`EIEC_ADDR_EDGE_B, 8'h00);
      rd(`EIEC_ADDR_REQ_A, 8'h00);
      report_and_stop;
   end
endmodule
`default_nettype wire
